/* File: shared/test_ctrl_defines.svh */
// Register offsets, field positions and timing figures of the test-control block.
`ifndef TEST_CTRL_DEFINES_SVH
`define TEST_CTRL_DEFINES_SVH
`define CLK_HZ 40000000
`define LINE_CODE_S 10
`define PORT_SEQ_S 5
`define ANSWER_WAIT_S 45
`define OFF_CONTROL 8'h00
`define OFF_COMMAND 8'h04
`define OFF_STATE 8'h08
`define OFF_EV_STATUS 8'h0C
`define OFF_EV_CLEAR 8'h10
`define OFF_EV_ENABLE 8'h14
`define OFF_MODEM 8'h18
`define OFF_MAP_BASE 8'h20
`define MON_NET_BIT 0
`define CMD_CODE_MSB 2
`define CMD_PORT_LSB 4
`define DIAL_START_BIT 0
`define ST_SENDING 0
`define ST_COMPLETE 1
`define ST_MON_NET 2
`define ST_DIALING 3
`define EV_DONE 0
`define EV_INVALID 1
`define EV_REJECT 2
`define EV_NO_ANSWER 3
`define EV_W 4
`define PATTERN_W 16
`define SLOTS 24
`define TIMER_W 31
`endif

/* File: shared/test_ctrl_pkg.sv */
// Types shared by the test-control block.
package test_ctrl_pkg;
  typedef enum logic [2:0] {
    line_loop_up_code,
    line_loop_down_code,
    v54_loop_activate,
    v54_loop_deactivate,
    fractional_loop_activate,
    fractional_loop_deactivate
  } cmd_t;
  typedef enum logic {idle_st, sending_st} send_state_t;
  typedef struct packed {
    logic net;
    logic equipment_side;
  } line_pair_t;
  typedef struct packed {
    logic net_in;
    logic net_out;
    logic equipment_side_in;
    logic equipment_side_out;
  } jack_t;
endpackage : test_ctrl_pkg

/* File: sim/far_end_unit.sv */
// Model of the far-end service unit that sits across the network line.
`timescale 1ns/10ps
module far_end_unit (
  input wire logic clock,
  input wire logic rst,
  input wire logic line_in,
  output logic line_out,
  output logic [15:0] window
);
  // The far end idles with marks, so a cut-off receive path shows as a drop to zero.
  assign line_out = 1'b1;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      window <= 16'h0000;
    end else begin
      window <= {window[14:0], line_in};
    end
  end
endmodule : far_end_unit

/* File: sim/tb_test_ctrl.sv */
// Self-checking bench for the test-control block.
`timescale 1ns/10ps
`include "test_ctrl_defines.svh"
module tb_test_ctrl
  import test_ctrl_pkg::*;
;
  localparam int NL = 40;
  localparam int NS = 30;
  localparam int NA = 50;
  localparam logic [15:0] PAT [6] = '{16'h8421, 16'h9249, 16'hA5C3, 16'h5A3C, 16'hF0E1, 16'h0F1E};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic equipment_side_bit = 1'b0;
  logic local_loop_active = 1'b0;
  logic answer_tone = 1'b0;
  logic far_bit, waitrequest, mon_in, mon_out, irq;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd_val, rd_single;
  line_pair_t own_tx = 2'b01;
  line_pair_t inject = 2'b10;
  line_pair_t toward, rx_pass, from_line;
  jack_t jacks = 4'h0;
  logic [4:0] slot_index = 5'h00;
  logic [15:0] window;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int t_done = 0;
  int t0 = 0;
  int el = 0;
  assign from_line = '{net: far_bit, equipment_side: equipment_side_bit};
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    slot_index <= (slot_index == 5'h17) ? 5'h00 : slot_index + 5'h01;
  end
  test_ctrl #(.LINE_CYCLES(NL), .SEQ_CYCLES(NS), .ANSWER_CYCLES(NA), .PAT_LINE_UP(PAT[0]),
    .PAT_LINE_DOWN(PAT[1]), .PAT_V54_UP(PAT[2]), .PAT_V54_DOWN(PAT[3]),
    .PAT_FRAC_UP(PAT[4]), .PAT_FRAC_DOWN(PAT[5])) i_dut (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .from_line(from_line), .own_tx(own_tx), .inject(inject), .jacks(jacks),
    .slot_index(slot_index), .local_loop_active(local_loop_active),
    .answer_tone(answer_tone), .toward(toward), .rx_pass(rx_pass), .mon_in(mon_in),
    .mon_out(mon_out), .irq(irq));
  far_end_unit i_far (.clock(clock), .rst(rst), .line_in(toward.net), .line_out(far_bit),
    .window(window));
  // The single-port build shares the bus so that its fixed selector can be read back.
  test_ctrl #(.SINGLE_PORT(1'b1), .LINE_CYCLES(NL), .SEQ_CYCLES(NS),
    .ANSWER_CYCLES(NA)) i_dut_single (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(rd_single), .waitrequest(), .from_line(from_line),
    .own_tx(own_tx), .inject(inject), .jacks(jacks), .slot_index(slot_index),
    .local_loop_active(local_loop_active), .answer_tone(answer_tone), .toward(),
    .rx_pass(), .mon_in(), .mon_out(), .irq());
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One bus cycle; the request is held until waitrequest is seen low at a rising edge.
  // Each call lets one edge pass before it raises a new request.
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd_val = readdata;
    t_done = cyc;
    read <= 1'b0;
    write <= 1'b0;
  endtask : access
  task automatic wait_irq();
    do @(negedge clock); while (irq !== 1'b1);
    el = cyc - t0;
  endtask : wait_irq
  task automatic wait_since(input int n);
    do @(negedge clock); while (cyc - t0 < n);
  endtask : wait_since
  function automatic logic is_rot(input logic [15:0] w, input logic [15:0] p);
    logic [31:0] d;
    d = {p, p};
    is_rot = 1'b0;
    for (int r = 0; r < 16; r++) begin
      if (d[r +: 16] == w) begin
        is_rot = 1'b1;
      end
    end
  endfunction : is_rot
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    access(1'b0, `OFF_CONTROL, 32'h0);
    chk("control", rd_val, 32'h0);
    access(1'b0, `OFF_STATE, 32'h0);
    chk("state", rd_val, 32'h0);
    chk("mon_in", {31'h0, mon_in}, 32'h1);
    chk("mon_out", {31'h0, mon_out}, 32'h0);
    access(1'b1, `OFF_CONTROL, 32'h1);
    access(1'b0, `OFF_STATE, 32'h0);
    chk("state", rd_val, 32'h4);
    repeat (3) @(negedge clock);
    chk("mon_in", {31'h0, mon_in}, 32'h0);
    chk("mon_out", {31'h0, mon_out}, 32'h1);
    access(1'b1, `OFF_CONTROL, 32'h0);
    access(1'b0, `OFF_CONTROL, 32'h0);
    chk("control", rd_val, 32'h0);
    chk("single control", rd_single, 32'h1);
    $display("test monitor done");
    equipment_side_bit <= 1'b1;
    jacks <= 4'hF;
    repeat (3) @(negedge clock);
    chk("toward", {30'h0, toward}, 32'h2);
    chk("rx_pass", {30'h0, rx_pass}, 32'h0);
    @(posedge clock);
    jacks <= 4'h0;
    repeat (3) @(negedge clock);
    chk("toward", {30'h0, toward}, 32'h1);
    chk("rx_pass", {30'h0, rx_pass}, 32'h3);
    $display("test jacks done");
    access(1'b0, `OFF_MAP_BASE + 8'h04, 32'h0);
    chk("map", rd_val, 32'h0);
    access(1'b1, `OFF_MAP_BASE + 8'h04, 32'h00FFFFFF);
    access(1'b1, `OFF_EV_ENABLE, 32'h1);
    access(1'b0, `OFF_EV_ENABLE, 32'h0);
    chk("enable", rd_val, 32'h1);
    access(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd_val, 32'h0);
    for (int c = 0; c < 6; c++) begin
      access(1'b1, `OFF_COMMAND, 32'h10 | 32'(c));
      t0 = t_done;
      if (c == 0) begin
        access(1'b1, `OFF_COMMAND, 32'h11);
        access(1'b1, `OFF_CONTROL, 32'h1);
        access(1'b0, `OFF_EV_STATUS, 32'h0);
        chk("reject", rd_val, 32'h4);
      end
      access(1'b0, `OFF_STATE, 32'h0);
      chk("sending", 32'(rd_val[1:0]), 32'h1);
      wait_since(22);
      chk("pattern", {31'h0, is_rot(window, PAT[c])}, 32'h1);
      wait_irq();
      chk("length", 32'(el), 32'((c < 2 ? NL : NS) + 2));
      access(1'b0, `OFF_STATE, 32'h0);
      chk("complete", 32'(rd_val[1:0]), 32'h2);
      access(1'b1, `OFF_EV_CLEAR, 32'hF);
      repeat (2) @(negedge clock);
      chk("irq", {31'h0, irq}, 32'h0);
    end
    $display("test codes done");
    access(1'b1, `OFF_COMMAND, 32'h22);
    t0 = t_done;
    wait_since(22);
    chk("unmapped slots", {16'h0, window}, 32'h0);
    wait_irq();
    access(1'b1, `OFF_EV_CLEAR, 32'hF);
    local_loop_active <= 1'b1;
    access(1'b1, `OFF_COMMAND, 32'h10);
    access(1'b0, `OFF_STATE, 32'h0);
    chk("refused", 32'(rd_val[0]), 32'h0);
    access(1'b0, `OFF_EV_STATUS, 32'h0);
    chk("invalid", rd_val, 32'h2);
    local_loop_active <= 1'b0;
    access(1'b1, `OFF_EV_CLEAR, 32'hF);
    access(1'b1, `OFF_COMMAND, 32'h07);
    access(1'b0, `OFF_EV_STATUS, 32'h0);
    chk("illegal code", rd_val, 32'h2);
    access(1'b1, `OFF_EV_CLEAR, 32'hF);
    $display("test refusals done");
    access(1'b1, `OFF_EV_ENABLE, 32'h8);
    access(1'b1, `OFF_MODEM, 32'h1);
    t0 = t_done;
    access(1'b0, `OFF_STATE, 32'h0);
    chk("dialing", 32'(rd_val[3]), 32'h1);
    wait_irq();
    chk("no answer time", {31'h0, el >= NA && el <= NA + 3}, 32'h1);
    access(1'b0, `OFF_EV_STATUS, 32'h0);
    chk("no answer", rd_val, 32'h8);
    access(1'b1, `OFF_EV_CLEAR, 32'hF);
    access(1'b1, `OFF_MODEM, 32'h1);
    repeat (10) @(posedge clock);
    answer_tone <= 1'b1;
    repeat (NA + 10) @(negedge clock);
    access(1'b0, `OFF_STATE, 32'h0);
    chk("answered", 32'(rd_val[3]), 32'h0);
    access(1'b0, `OFF_EV_STATUS, 32'h0);
    chk("answered event", rd_val, 32'h0);
    $display("test modem done");
    report_and_stop();
  end
endmodule : tb_test_ctrl

/* File: verilog/test_ctrl.sv */
// Monitor jack selection, break-in jacks and remote loop code sender.
`timescale 1ns/10ps
`include "test_ctrl_defines.svh"

module test_ctrl
  import test_ctrl_pkg::*;
#(
  parameter int NUM_PORTS = 4,
  parameter bit SINGLE_PORT = 1'b0,
  parameter int unsigned LINE_CYCLES = `LINE_CODE_S * `CLK_HZ,
  parameter int unsigned SEQ_CYCLES = `PORT_SEQ_S * `CLK_HZ,
  parameter int unsigned ANSWER_CYCLES = `ANSWER_WAIT_S * `CLK_HZ,
  parameter logic [`PATTERN_W-1:0] PAT_LINE_UP = 16'h8421,
  parameter logic [`PATTERN_W-1:0] PAT_LINE_DOWN = 16'h9249,
  parameter logic [`PATTERN_W-1:0] PAT_V54_UP = 16'hA5C3,
  parameter logic [`PATTERN_W-1:0] PAT_V54_DOWN = 16'h5A3C,
  parameter logic [`PATTERN_W-1:0] PAT_FRAC_UP = 16'hF0E1,
  parameter logic [`PATTERN_W-1:0] PAT_FRAC_DOWN = 16'h0F1E
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire line_pair_t from_line,
  input wire line_pair_t own_tx,
  input wire line_pair_t inject,
  input wire jack_t jacks,
  input wire logic [4:0] slot_index,
  input wire logic local_loop_active,
  input wire logic answer_tone,
  output line_pair_t toward,
  output line_pair_t rx_pass,
  output logic mon_in,
  output logic mon_out,
  output logic irq
);
  localparam int PORT_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

  logic mon_net;
  send_state_t state;
  cmd_t cmd;
  logic [PORT_W-1:0] port;
  logic [`TIMER_W-1:0] timer;
  logic [`PATTERN_W-1:0] pattern;
  logic complete;
  logic [`SLOTS-1:0] chan_map [NUM_PORTS];
  logic dialing;
  logic [`TIMER_W-1:0] dial_timer;
  logic [`EV_W-1:0] ev_status;
  logic [`EV_W-1:0] ev_enable;
  logic [`EV_W-1:0] ev_set;
  logic [31:0] next_readdata;
  line_pair_t next_toward;

  wire wr = write && !waitrequest;
  wire cmd_wr = wr && (address == `OFF_COMMAND);
  wire [2:0] cmd_code = writedata[`CMD_CODE_MSB:0];
  wire [PORT_W-1:0] cmd_port = writedata[`CMD_PORT_LSB +: PORT_W];
  wire cmd_legal = (cmd_code <= 3'(fractional_loop_deactivate)) &&
                   (int'(cmd_port) < NUM_PORTS);
  wire cmd_is_line = (cmd_code == 3'(line_loop_up_code)) ||
                     (cmd_code == 3'(line_loop_down_code));
  wire is_line = (cmd == line_loop_up_code) || (cmd == line_loop_down_code);
  wire cmd_start = cmd_wr && (state == idle_st) && !local_loop_active && cmd_legal;
  // Slot numbers of 24 and above are framing positions and never carry a port sequence.
  wire slot_hit = (int'(slot_index) < `SLOTS) && chan_map[port][slot_index];
  wire code_on = (state == sending_st) && (is_line || slot_hit);
  wire [7:0] map_off = address - `OFF_MAP_BASE;
  wire map_sel = (address >= `OFF_MAP_BASE) && (int'(map_off[7:2]) < NUM_PORTS);
  wire [PORT_W-1:0] map_idx = map_off[2 +: PORT_W];

  // Avalon slave: every access sees exactly one wait cycle, so read data and
  // write effect both land on the single edge where waitrequest is low.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if ((read || write) && waitrequest) begin
        readdata <= next_readdata;
      end
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address)
      `OFF_CONTROL: next_readdata[`MON_NET_BIT] = mon_net;
      `OFF_STATE: begin
        next_readdata[`ST_SENDING] = (state == sending_st);
        next_readdata[`ST_COMPLETE] = complete;
        next_readdata[`ST_MON_NET] = mon_net;
        next_readdata[`ST_DIALING] = dialing;
      end
      `OFF_EV_STATUS: next_readdata[`EV_W-1:0] = ev_status;
      `OFF_EV_ENABLE: next_readdata[`EV_W-1:0] = ev_enable;
      default: begin
        if (map_sel) begin
          next_readdata[`SLOTS-1:0] = chan_map[map_idx];
        end
      end
    endcase
  end

  // The single-port build has no selector; its taps are fixed on the network.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mon_net <= SINGLE_PORT;
    end else if (!SINGLE_PORT && wr && address == `OFF_CONTROL) begin
      mon_net <= writedata[`MON_NET_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        chan_map[i] <= '0;
      end
    end else if (wr && map_sel) begin
      chan_map[map_idx] <= writedata[`SLOTS-1:0];
    end
  end

  // Code sender. A command write while busy neither restarts nor changes the
  // running code; it only raises the reject event.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= idle_st;
      cmd <= line_loop_up_code;
      port <= '0;
      timer <= '0;
      pattern <= '0;
      complete <= 1'b0;
    end else begin
      unique case (state)
        idle_st: begin
          if (cmd_start) begin
            state <= sending_st;
            cmd <= cmd_t'(cmd_code);
            port <= cmd_port;
            complete <= 1'b0;
            timer <= cmd_is_line ? `TIMER_W'(LINE_CYCLES) : `TIMER_W'(SEQ_CYCLES);
            case (cmd_t'(cmd_code))
              line_loop_up_code: pattern <= PAT_LINE_UP;
              line_loop_down_code: pattern <= PAT_LINE_DOWN;
              v54_loop_activate: pattern <= PAT_V54_UP;
              v54_loop_deactivate: pattern <= PAT_V54_DOWN;
              fractional_loop_activate: pattern <= PAT_FRAC_UP;
              default: pattern <= PAT_FRAC_DOWN;
            endcase
          end
        end
        sending_st: begin
          timer <= timer - `TIMER_W'(1);
          if (code_on) begin
            pattern <= {pattern[`PATTERN_W-2:0], pattern[`PATTERN_W-1]};
          end
          if (timer == `TIMER_W'(1)) begin
            state <= idle_st;
            complete <= 1'b1;
          end
        end
      endcase
    end
  end

  // A start written while dialing is ignored, so the answer window is never stretched.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dialing <= 1'b0;
      dial_timer <= '0;
    end else if (!dialing) begin
      if (wr && address == `OFF_MODEM && writedata[`DIAL_START_BIT]) begin
        dialing <= 1'b1;
        dial_timer <= `TIMER_W'(ANSWER_CYCLES);
      end
    end else begin
      dial_timer <= dial_timer - `TIMER_W'(1);
      if (answer_tone || dial_timer == `TIMER_W'(1)) begin
        dialing <= 1'b0;
      end
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[`EV_DONE] = (state == sending_st) && (timer == `TIMER_W'(1));
    ev_set[`EV_INVALID] = cmd_wr && (state == idle_st) &&
                          (local_loop_active || !cmd_legal);
    ev_set[`EV_REJECT] = cmd_wr && (state == sending_st);
    ev_set[`EV_NO_ANSWER] = dialing && !answer_tone && (dial_timer == `TIMER_W'(1));
  end

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ev_status <= '0;
      ev_enable <= '0;
      irq <= 1'b0;
    end else begin
      ev_status <= (ev_status & ~((wr && address == `OFF_EV_CLEAR) ?
                   writedata[`EV_W-1:0] : `EV_W'(0))) | ev_set;
      if (wr && address == `OFF_EV_ENABLE) begin
        ev_enable <= writedata[`EV_W-1:0];
      end
      irq <= |(ev_status & ev_enable);
    end
  end

  always_comb begin
    next_toward.net = jacks.net_in ? inject.net :
                      code_on ? pattern[`PATTERN_W-1] : own_tx.net;
    next_toward.equipment_side = jacks.equipment_side_in ? inject.equipment_side : own_tx.equipment_side;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      toward <= '0;
      rx_pass <= '0;
      mon_in <= 1'b0;
      mon_out <= 1'b0;
    end else begin
      toward <= next_toward;
      rx_pass.net <= jacks.net_out ? 1'b0 : from_line.net;
      rx_pass.equipment_side <= jacks.equipment_side_out ? 1'b0 : from_line.equipment_side;
      mon_in <= mon_net ? next_toward.net : next_toward.equipment_side;
      mon_out <= mon_net ? from_line.net : from_line.equipment_side;
    end
  end

  sequence s_last_tick;
    state == sending_st && timer == `TIMER_W'(1);
  endsequence
  sequence s_done;
    state == idle_st && complete && ev_status[`EV_DONE];
  endsequence

  AST_MON_IN_TAP: assert property (@(posedge clock) disable iff (rst)
    ##1 mon_in == ($past(mon_net) ? toward.net : toward.equipment_side))
    else $error("monitor input tap follows wrong path");
  AST_MON_OUT_TAP: assert property (@(posedge clock) disable iff (rst)
    !mon_net |=> mon_out == $past(from_line.equipment_side))
    else $error("monitor output tap follows wrong path");
  AST_SINGLE_NET: assert property (@(posedge clock) disable iff (rst)
    SINGLE_PORT |-> mon_net)
    else $error("single-port build left network monitoring");
  AST_NET_INJECT: assert property (@(posedge clock) disable iff (rst)
    jacks.net_in |=> toward.net == $past(inject.net))
    else $error("network-in jack not sent toward network");
  AST_NET_CUT: assert property (@(posedge clock) disable iff (rst)
    jacks.net_out |=> !rx_pass.net)
    else $error("network signal not cut off");
  AST_EQUIPMENT_SIDE_INJECT: assert property (@(posedge clock) disable iff (rst)
    jacks.equipment_side_in |=> toward.equipment_side == $past(inject.equipment_side))
    else $error("equipment-in jack not sent toward equipment");
  AST_EQUIPMENT_SIDE_CUT: assert property (@(posedge clock) disable iff (rst)
    jacks.equipment_side_out |=> !rx_pass.equipment_side)
    else $error("equipment signal not cut off");
  AST_LINE_START: assert property (@(posedge clock) disable iff (rst)
    cmd_start && cmd_is_line |=> state == sending_st && timer == `TIMER_W'(LINE_CYCLES))
    else $error("line code not loaded for full duration");
  AST_FINISH: assert property (@(posedge clock) disable iff (rst)
    s_last_tick |=> s_done)
    else $error("completion not reported after sending");
  AST_BUSY_HOLD: assert property (@(posedge clock) disable iff (rst)
    state == sending_st && timer != `TIMER_W'(1) |=>
      state == sending_st && cmd == $past(cmd) && timer == $past(timer) - `TIMER_W'(1))
    else $error("running code disturbed by new command");
  AST_LOCAL_REFUSE: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && state == idle_st && local_loop_active |=>
      state == idle_st && ev_status[`EV_INVALID])
    else $error("remote command accepted during local loopback");
  AST_SLOT_ONLY: assert property (@(posedge clock) disable iff (rst)
    state == sending_st && !is_line && !slot_hit && !jacks.net_in |=>
      toward.net == $past(own_tx.net))
    else $error("port sequence outside its timeslots");
  AST_NO_ANSWER: assert property (@(posedge clock) disable iff (rst)
    dialing && !answer_tone && dial_timer == `TIMER_W'(1) |=>
      !dialing && ev_status[`EV_NO_ANSWER])
    else $error("no-answer not declared at timeout");

  // The slave inserts exactly one wait cycle and never stretches its answer.
  AST_WAIT_DROPS: assert property (@(posedge clock) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered after one wait cycle");
  AST_WAIT_ONE: assert property (@(posedge clock) disable iff (rst)
    !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_MON_OUT_NET: assert property (@(posedge clock) disable iff (rst)
    mon_net |=> mon_out == $past(from_line.net))
    else $error("monitor output tap misses network side");
  AST_NET_PASS: assert property (@(posedge clock) disable iff (rst)
    !jacks.net_out |=> rx_pass.net == $past(from_line.net))
    else $error("network signal cut with jack free");
  AST_EQUIPMENT_SIDE_PASS: assert property (@(posedge clock) disable iff (rst)
    !jacks.equipment_side_out |=> rx_pass.equipment_side == $past(from_line.equipment_side))
    else $error("equipment signal cut with jack free");
  AST_CODE_OUT: assert property (@(posedge clock) disable iff (rst)
    code_on && !jacks.net_in |=> toward.net == $past(pattern[`PATTERN_W-1]))
    else $error("loop code bit not sent toward network");
  AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (rst)
    state == idle_st && !jacks.net_in |=> toward.net == $past(own_tx.net))
    else $error("loop code still sent after completion");
  AST_SENDING_STATUS: assert property (@(posedge clock) disable iff (rst)
    state == sending_st |-> !complete)
    else $error("complete reported while still sending");
  AST_SEQ_START: assert property (@(posedge clock) disable iff (rst)
    cmd_start && !cmd_is_line |=>
      state == sending_st && timer == `TIMER_W'(SEQ_CYCLES))
    else $error("port sequence not loaded for its duration");
  AST_ANSWER_STOP: assert property (@(posedge clock) disable iff (rst)
    dialing && answer_tone |=> !dialing)
    else $error("dialing kept on after answer tone");
  AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> irq == $past(|(ev_status & ev_enable)))
    else $error("interrupt does not follow enabled status");
  AST_SET_WINS: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (ev_status & $past(ev_set)) == $past(ev_set))
    else $error("event lost against a clear");
endmodule : test_ctrl
